/* tb.sv */
/* bench of the slave port: page, byte, random, current and sequential
   access, protect, identity, busy and supply lockout.
   assumes: tws_master_model drives the bus, sda has a pull-up. */
`timescale 1ns/100ps
module tb import tws_pkg::*; ;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic power_good = 1'h1;
    logic prot = 1'h0;
    logic [ID_W-1:0] ids = 3'h5;
    logic scl, pull, sda, sda_o, sda_oe, busy, locked;
    logic [7:0] shadow [0:MEM_DEPTH-1];
    int num_errors = 0;
    int check_count = 0;
    always #50 clk = !clk;
    assign sda = !(pull || sda_oe);
    tws_master_model master (.scl(scl), .pull(pull), .sda(sda));
    tws_slave_port #(.PROG_CYCLES_P(20)) dut (.clk(clk), .rst(rst), .power_good(power_good),
        .busy(busy), .locked(locked), .scl(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .bus_identity_pins(ids), .write_protect_input(prot));
    task automatic results();
        $display("checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    task automatic wait_st(input logic b, input logic l);
        int n;
        n = 0;
        while ((busy !== b || locked !== l) && n < 400) begin
            @(negedge clk);
            n++;
        end
        if (busy !== b || locked !== l) begin
            num_errors++;
            results();
        end
    endtask : wait_st
    task automatic put_chk(input logic [7:0] d, input logic exp, input string what);
        logic ack;
        master.put_byte(d, ack);
        check(what, {7'h0, exp}, {7'h0, ack});
    endtask : put_chk
    function automatic logic [7:0] sel(input logic [2:0] hi, input logic dir);
        return {SEL_FIXED_VAL, 3'h5, hi, dir};
    endfunction : sel
    // protected writes send all n data bytes and expect a nack on each: the slave goes idle after the first nack
    task automatic wr_seq(input logic [10:0] a, input int n, input logic [7:0] base);
        master.start_cond();
        put_chk(sel(a[10:8], 1'h0), 1'h1, "select ack");
        put_chk(a[7:0], 1'h1, "address ack");
        for (int k = 0; k < n; k++) begin
            put_chk(base + 8'(k), !prot, "data ack");
            if (!prot) begin
                shadow[{a[10:4], a[3:0] + 4'(k)}] = base + 8'(k);
            end
        end
        master.stop_cond();
    endtask : wr_seq
    task automatic prog_wait();
        wait_st(1'h1, 1'h0);
        wait_st(1'h0, 1'h0);
    endtask : prog_wait
    task automatic rd_seq(input logic [10:0] a, input int n, input logic rnd);
        logic [7:0] d;
        master.start_cond();
        if (rnd) begin
            put_chk(sel(a[10:8], 1'h0), 1'h1, "select ack");
            put_chk(a[7:0], 1'h1, "address ack");
            master.start_cond();
        end
        put_chk(sel(a[10:8], 1'h1), 1'h1, "read select ack");
        for (int k = 0; k < n; k++) begin
            master.get_byte(k < n - 1, d);
            check("read data", shadow[a + 11'(k)], d);
        end
        master.stop_cond();
    endtask : rd_seq
    initial begin
        #5000000;
        num_errors++;
        results();
    end
    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        check("locked in reset", 8'h01, {7'h0, locked});
        rst = 1'h0;
        wait_st(1'h0, 1'h0);
        wr_seq(11'h3F5, 17, 8'h20);
        prog_wait();
        rd_seq(11'h3F0, 16, 1'h1);
        wr_seq(11'h7FF, 1, 8'hA5);
        prog_wait();
        wr_seq(11'h000, 2, 8'h5A);
        prog_wait();
        rd_seq(11'h7FF, 2, 1'h1);
        rd_seq(11'h001, 1, 1'h0);
        @(negedge clk);
        prot = 1'h1;
        wr_seq(11'h000, 1, 8'hFF);
        repeat (40) @(negedge clk);
        check("busy", 8'h00, {7'h0, busy});
        rd_seq(11'h000, 1, 1'h1);
        rd_seq(11'h001, 1, 1'h0);
        @(negedge clk);
        prot = 1'h0;
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            ids = 3'(i);
            master.start_cond();
            put_chk(sel(3'h0, 1'h0), i == 5, "identity ack");
            master.stop_cond();
        end
        @(negedge clk);
        ids = 3'h5;
        master.start_cond();
        put_chk({1'h0, 3'h5, 3'h0, 1'h1}, 1'h0, "fixed bit ack");
        master.stop_cond();
        wr_seq(11'h123, 1, 8'h3C);
        wait_st(1'h1, 1'h0);
        master.start_cond();
        put_chk(sel(3'h1, 1'h1), 1'h0, "select while busy");
        master.stop_cond();
        wait_st(1'h0, 1'h0);
        rd_seq(11'h123, 1, 1'h1);
        @(negedge clk);
        power_good = 1'h0;
        wait_st(1'h0, 1'h1);
        master.start_cond();
        put_chk(sel(3'h3, 1'h1), 1'h0, "select while locked");
        master.stop_cond();
        @(negedge clk);
        power_good = 1'h1;
        wait_st(1'h0, 1'h0);
        rd_seq(11'h3F5, 1, 1'h1);
        results();
    end
endmodule : tb

/* tws_master_model.sv */
/* two-wire bus master model: start, stop, bytes out and in.
   assumes: the bench resolves sda with a pull-up. */
`timescale 1ns/100ps
module tws_master_model (
    // bus
    output logic scl,
    output logic pull,
    input wire logic sda
);
    // scl stands high between frames, 32 ns period inside them
    initial begin
        scl = 1'h1;
        pull = 1'h0;
    end
    task automatic bit_cyc(input logic low, output logic seen);
        pull = low;
        #8 scl = 1'h1;
        #8 seen = sda;
        #8 scl = 1'h0;
        #8;
    endtask : bit_cyc
    task automatic start_cond();
        pull = 1'h0;
        #8 scl = 1'h1;
        #16 pull = 1'h1;
        #16 scl = 1'h0;
        #8;
    endtask : start_cond
    // long bus-free time lets the slave take in the stop
    task automatic stop_cond();
        pull = 1'h1;
        #8 scl = 1'h1;
        #16 pull = 1'h0;
        #300;
    endtask : stop_cond
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(!d[i], s);
        end
        bit_cyc(1'h0, s);
        ack = !s;
    endtask : put_byte
    task automatic get_byte(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'h0, d[i]);
        end
        bit_cyc(more, s);
    endtask : get_byte
endmodule : tws_master_model

/* tws_mem.sv */
/*
 * simple two-clock memory: one write port, one read port with registered data.
 * assumes: the two ports never touch the same word in overlapping cycles.
 */
`timescale 1ns/100ps
module tws_mem #(
    parameter int DW = 8,
    parameter int AW = 11
) (
    // write side
    input wire logic wclk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // read side
    input wire logic rclk,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);

    logic [DW-1:0] cells [0:(1<<AW)-1];

    always_ff @(posedge wclk) begin
        if (we) begin
            cells[waddr] <= wdata;
        end
    end

    always_ff @(posedge rclk) begin
        rdata <= cells[raddr];
    end

endmodule : tws_mem

/* tws_pkg.sv */
/*
 * constants, enumerations and state records of the two-wire memory slave port.
 * assumes: imported whole by tws_slave_port and its checker; tws_mem does not import it.
 */
package tws_pkg;

    // ************************************************
    // array and select byte
    // ************************************************
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 11;
    localparam int MEM_DEPTH = 2048;
    localparam int PAGE_W = 4;
    localparam int PAGE_BYTES = 16;
    localparam int BLOCK_W = ADDR_W - PAGE_W;
    localparam int ID_W = 3;
    localparam int AHI_W = 3;
    localparam int SEL_FIXED_BIT = 7;
    localparam int SEL_ID_LSB = 4;
    localparam int SEL_AHI_LSB = 1;
    localparam int SEL_DIR_BIT = 0;
    localparam logic SEL_FIXED_VAL = 1'h1;
    localparam logic DIR_READ = 1'h1;

    // ************************************************
    // bit counting and pointer steps
    // ************************************************
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [CNT_W-1:0] ACK_SLOT = 4'h8;
    localparam logic [PAGE_W-1:0] PAGE_ONE = 4'h1;
    localparam logic [ADDR_W-1:0] PTR_ONE = 11'h001;
    localparam logic [PAGE_W:0] IDX_ONE = 5'h01;
    localparam logic [PAGE_W:0] IDX_LAST = 5'h10;

    // ************************************************
    // timing
    // ************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int PROG_TIME_NS = 10000000;
    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_CNT_W = 24;

    // ************************************************
    // states and records
    // ************************************************
    typedef enum logic [2:0] {
        TWS_IDLE = 3'h0,
        TWS_SEL = 3'h1,
        TWS_ADDR = 3'h2,
        TWS_WDATA = 3'h3,
        TWS_RDATA = 3'h4
    } tws_phase_t;

    typedef enum logic [1:0] {
        TWS_READY = 2'h0,
        TWS_COPY = 2'h1,
        TWS_HOLD = 2'h2
    } tws_prog_t;

    typedef struct packed {
        tws_phase_t phase;
        logic [CNT_W-1:0] bitcnt;
        logic [BYTE_W-1:0] shreg;
        logic [ADDR_W-1:0] ptr;
        logic dir;
        logic [PAGE_BYTES-1:0] wmask;
        logic [BLOCK_W-1:0] page;
        logic drv;
        logic start_seen;
        logic busy_s1;
        logic busy_s2;
        logic wp_s1;
        logic wp_s2;
        logic [ID_W-1:0] id_s1;
        logic [ID_W-1:0] id_s2;
    } tws_link_t;

    typedef struct packed {
        logic pg_s1;
        logic pg_s2;
        logic run;
        logic stop_s1;
        logic stop_s2;
        logic stop_s3;
        tws_prog_t state;
        logic busy;
        logic [PAGE_W:0] idx;
        logic [PAGE_BYTES-1:0] mask;
        logic [BLOCK_W-1:0] page;
        logic [PROG_CNT_W-1:0] timer;
    } tws_ctl_t;

    // select byte addressed to this slave
    function automatic logic tws_sel_match(input logic [BYTE_W-1:0] sel,
                                           input logic [ID_W-1:0] id);
        return (sel[SEL_FIXED_BIT] == SEL_FIXED_VAL) && (sel[SEL_ID_LSB +: ID_W] == id);
    endfunction : tws_sel_match

endpackage : tws_pkg

/* tws_slave_port.sv */
/*
 * two-wire serial memory slave port: bus framing, select decode, read and
 * page write, self-timed programming and supply lockout.
 * assumes: scl is a clean clock from the bus master, sda_i is the resolved
 * wire level, clk runs free at 10 MHz, rst is held for a few clk edges.
 */
//
// Behaviour
// - array of 2048 bytes reached by an 11-bit byte address
// - three identity pins pick one of eight slaves on a shared bus
// - slave only; every bus transfer is clocked by the master's scl
// - each received byte acknowledged by pulling sda low in ninth clock
// - select byte msb first: fixed 1, identity, high address, direction
// - direction 1 returns byte at pointer regardless of write protect
// - random read: write select, low address, restart, read select
// - reads continue at successive addresses while master acknowledges
// - byte write: select, address, one data byte, only with protect low
// - page write takes up to 16 data bytes, protect low
// - below supply threshold: reset held, bus ignored, nothing runs
// - supply falling below threshold blocks all operations again
// - protect high: select and address acknowledged, data not, no write
// - STOP after write starts programming; STOP after read means standby
// - sda sampled on scl rise; START watched for also during programming
`timescale 1ns/100ps
module tws_slave_port import tws_pkg::*; #(
    parameter int PROG_CYCLES_P = PROG_CYCLES
) (
    // system side
    input wire logic clk,
    input wire logic rst,
    input wire logic power_good,
    // status
    output logic busy,
    output logic locked,
    // bus pins
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // straps
    input wire logic [ID_W-1:0] bus_identity_pins,
    input wire logic write_protect_input
);

    // ************************************************
    // declarations
    // ************************************************
    tws_link_t l;
    tws_link_t next_l;
    tws_ctl_t c;
    tws_ctl_t next_c;
    logic lock;
    logic start_tog;
    logic stop_tog;
    logic [BYTE_W-1:0] shifted;
    logic [BYTE_W-1:0] rd_data;
    logic [BYTE_W-1:0] buf_data;
    logic buf_we;
    logic mem_we;
    logic [PAGE_W:0] idx_prev;
    logic [ADDR_W-1:0] mem_waddr;

    // lock is a flop output, so it is glitch-free as a reset for the link side
    assign lock = !c.run;
    assign locked = lock;
    assign busy = c.busy;
    assign sda_o = 1'h0;
    assign shifted = {l.shreg[BYTE_W-2:0], sda_i};
    assign idx_prev = c.idx - IDX_ONE;
    assign mem_waddr = {c.page, idx_prev[PAGE_W-1:0]};

    // ************************************************
    // start and stop detection
    // ************************************************
    // sda edges while scl is high; we only move sda with scl low
    always_ff @(negedge sda_i or posedge lock) begin
        if (lock) begin
            start_tog <= 1'h0;
        end else if (scl) begin
            start_tog <= ~start_tog;
        end
    end

    always_ff @(posedge sda_i or posedge lock) begin
        if (lock) begin
            stop_tog <= 1'h0;
        end else if (scl) begin
            stop_tog <= ~stop_tog;
        end
    end

    // ************************************************
    // link side, clocked by scl
    // ************************************************
    always_comb begin
        next_l = l;
        buf_we = 1'h0;
        next_l.busy_s1 = c.busy;
        next_l.busy_s2 = l.busy_s1;
        next_l.wp_s1 = write_protect_input;
        next_l.wp_s2 = l.wp_s1;
        next_l.id_s1 = bus_identity_pins;
        next_l.id_s2 = l.id_s1;
        if (start_tog != l.start_seen) begin
            // first rising edge after START or restart carries select bit 7
            next_l.start_seen = start_tog;
            next_l.phase = TWS_SEL;
            next_l.bitcnt = CNT_ONE;
            next_l.shreg = shifted;
            next_l.wmask = '0;
            next_l.drv = 1'h0;
        end else begin
            case (l.phase)
                TWS_SEL, TWS_ADDR, TWS_WDATA: begin
                    if (l.bitcnt != ACK_SLOT) begin
                        next_l.shreg = shifted;
                        next_l.bitcnt = l.bitcnt + CNT_ONE;
                        if (next_l.bitcnt == ACK_SLOT) begin
                            case (l.phase)
                                TWS_SEL: begin
                                    // busy refusal lets the master poll for completion
                                    if (tws_sel_match(shifted, l.id_s2) && !l.busy_s2) begin
                                        next_l.drv = 1'h1;
                                        next_l.ptr[ADDR_W-1 -: AHI_W] =
                                            shifted[SEL_AHI_LSB +: AHI_W];
                                        next_l.dir = shifted[SEL_DIR_BIT];
                                    end else begin
                                        next_l.phase = TWS_IDLE;
                                    end
                                end
                                TWS_ADDR: begin
                                    next_l.drv = 1'h1;
                                    next_l.ptr[BYTE_W-1:0] = shifted;
                                end
                                default: begin
                                    if (!l.wp_s2) begin
                                        next_l.drv = 1'h1;
                                        buf_we = 1'h1;
                                        next_l.wmask[l.ptr[PAGE_W-1:0]] = 1'h1;
                                        next_l.page = l.ptr[ADDR_W-1:PAGE_W];
                                        next_l.ptr[PAGE_W-1:0] =
                                            l.ptr[PAGE_W-1:0] + PAGE_ONE;
                                    end else begin
                                        next_l.phase = TWS_IDLE;
                                    end
                                end
                            endcase
                        end
                    end else begin
                        // ninth clock done: release the acknowledge
                        next_l.bitcnt = CNT_ZERO;
                        next_l.drv = 1'h0;
                        if (l.phase == TWS_SEL && l.dir == DIR_READ) begin
                            next_l.phase = TWS_RDATA;
                            next_l.shreg = rd_data;
                            next_l.drv = !rd_data[BYTE_W-1];
                        end else if (l.phase == TWS_SEL) begin
                            next_l.phase = TWS_ADDR;
                        end else begin
                            next_l.phase = TWS_WDATA;
                        end
                    end
                end
                TWS_RDATA: begin
                    if (l.bitcnt != ACK_SLOT) begin
                        next_l.shreg = {l.shreg[BYTE_W-2:0], 1'h0};
                        next_l.bitcnt = l.bitcnt + CNT_ONE;
                        if (next_l.bitcnt == ACK_SLOT) begin
                            next_l.drv = 1'h0;
                            next_l.ptr = l.ptr + PTR_ONE;
                        end else begin
                            next_l.drv = !next_l.shreg[BYTE_W-1];
                        end
                    end else if (!sda_i) begin
                        // master acknowledged: next byte, pointer already moved
                        next_l.bitcnt = CNT_ZERO;
                        next_l.shreg = rd_data;
                        next_l.drv = !rd_data[BYTE_W-1];
                    end else begin
                        next_l.phase = TWS_IDLE;
                        next_l.drv = 1'h0;
                    end
                end
                default: begin
                    next_l.drv = 1'h0;
                end
            endcase
        end
    end

    always_ff @(posedge scl or posedge lock) begin
        if (lock) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    // sda only moves while scl is low, so it never fakes a start or stop
    always_ff @(negedge scl or posedge lock) begin
        if (lock) begin
            sda_oe <= 1'h0;
        end else begin
            sda_oe <= l.drv;
        end
    end

    // ************************************************
    // programming side, clocked by clk
    // ************************************************
    always_comb begin
        next_c = c;
        mem_we = 1'h0;
        next_c.pg_s1 = power_good;
        next_c.pg_s2 = c.pg_s1;
        next_c.run = c.pg_s2;
        next_c.stop_s1 = stop_tog;
        next_c.stop_s2 = c.stop_s1;
        next_c.stop_s3 = c.stop_s2;
        case (c.state)
            TWS_READY: begin
                // link side is quiet after stop, so its mask and page are stable here
                if (c.stop_s2 != c.stop_s3 && l.wmask != '0) begin
                    next_c.state = TWS_COPY;
                    next_c.busy = 1'h1;
                    next_c.mask = l.wmask;
                    next_c.page = l.page;
                    next_c.idx = '0;
                end
            end
            TWS_COPY: begin
                // buffer read data lags its address by one cycle
                next_c.idx = c.idx + IDX_ONE;
                if (c.idx != '0) begin
                    mem_we = c.mask[idx_prev[PAGE_W-1:0]];
                end
                if (c.idx == IDX_LAST) begin
                    next_c.state = TWS_HOLD;
                    next_c.timer = PROG_CNT_W'(PROG_CYCLES_P - 1);
                end
            end
            TWS_HOLD: begin
                if (c.timer == '0) begin
                    next_c.state = TWS_READY;
                    next_c.busy = 1'h0;
                end else begin
                    next_c.timer = c.timer - PROG_CNT_W'(1);
                end
            end
            default: begin
                next_c.state = TWS_READY;
                next_c.busy = 1'h0;
            end
        endcase
        // brown-out abandons any cycle in progress
        if (!c.run) begin
            next_c.state = TWS_READY;
            next_c.busy = 1'h0;
            mem_we = 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            c <= '0;
        end else begin
            c <= next_c;
        end
    end

    // ************************************************
    // storage
    // ************************************************
    // page latch: filled from the bus, drained by the programming cycle
    tws_mem #(
        .DW(BYTE_W),
        .AW(PAGE_W)
    ) u_page (
        .wclk(scl),
        .we(buf_we),
        .waddr(l.ptr[PAGE_W-1:0]),
        .wdata(shifted),
        .rclk(clk),
        .raddr(c.idx[PAGE_W-1:0]),
        .rdata(buf_data)
    );

    // main array; read address is the next pointer so data is ready at the ack edge
    tws_mem #(
        .DW(BYTE_W),
        .AW(ADDR_W)
    ) u_array (
        .wclk(clk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(buf_data),
        .rclk(scl),
        .raddr(next_l.ptr),
        .rdata(rd_data)
    );

endmodule : tws_slave_port

/* tws_slave_port_asserts.sv */
/* pin checker of the two-wire slave port.
   assumes: bound into tws_slave_port, sda_i is the resolved wire. */
`timescale 1ns/100ps
module tws_slave_port_asserts import tws_pkg::*; #(
    parameter int PROG_CYCLES_P = 20
) (
    // system
    input wire logic clk,
    input wire logic rst,
    input wire logic power_good,
    input wire logic busy,
    input wire logic locked,
    // bus
    input wire logic scl,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    // straps
    input wire logic [ID_W-1:0] bus_identity_pins,
    input wire logic write_protect_input
);
    // ******
    // frame tracking
    // ******
    logic tog;
    logic seen;
    logic first;
    logic [3:0] nbit;
    logic [1:0] nbyte;
    logic [7:0] shv;
    logic [31:0] blen;
    // a start flips a flag; the scl side sees the flip at the next rise
    always_ff @(negedge sda_i or posedge locked) begin
        if (locked) begin
            tog <= 1'h0;
        end else if (scl) begin
            tog <= !tog;
        end
    end
    always_ff @(posedge scl or posedge locked) begin
        if (locked) begin
            seen <= 1'h0;
            first <= 1'h0;
            nbit <= 4'h0;
            nbyte <= 2'h0;
            shv <= 8'h00;
        end else begin
            seen <= tog;
            first <= (tog != seen) || (first && nbit != 4'h8);
            nbit <= (tog != seen || nbit == 4'h9) ? 4'h1 : nbit + 4'h1;
            // byte index in the frame: 0 select, 1 address, 2 first and later data
            nbyte <= (tog != seen) ? 2'h0 : nbyte + {1'h0, nbit == 4'h8 && nbyte != 2'h2};
            shv <= {shv[6:0], sda_i};
        end
    end
    always_ff @(posedge clk) begin
        blen <= (rst || !busy) ? 32'h0 : blen + 32'h1;
    end
    // ******
    // properties
    // ******
    AST_LOCK_ON_DROP: assert property (@(posedge clk) disable iff (rst)
        !power_good |-> ##[1:4] locked) else $error("locked late after supply drop");
    AST_UNLOCK: assert property (@(posedge clk) disable iff (rst)
        power_good [*5] |-> !locked) else $error("still locked with supply good");
    AST_QUIET_LOCKED: assert property (@(posedge clk) disable iff (rst)
        locked |-> !sda_oe) else $error("sda driven while locked");
    AST_OPEN_DRAIN: assert property (@(posedge clk) disable iff (rst)
        sda_oe |-> sda_o == 1'h0) else $error("sda driven high");
    AST_PROG_LEN: assert property (@(posedge clk) disable iff (rst || locked)
        $fell(busy) |-> blen >= PROG_CYCLES_P && blen <= PROG_CYCLES_P + 40)
        else $error("programming time off");
    AST_SEL_QUIET: assert property (@(posedge scl) disable iff (locked)
        first && nbit != 4'h8 |-> !sda_oe) else $error("sda driven during select");
    AST_SEL_NACK: assert property (@(posedge scl) disable iff (locked)
        first && nbit == 4'h8 && (!shv[7] || shv[6:4] != bus_identity_pins) |-> !sda_oe)
        else $error("foreign select acknowledged");
    AST_SEL_ACK: assert property (@(posedge scl) disable iff (locked)
        first && nbit == 4'h8 && shv[7] && shv[6:4] == bus_identity_pins
        && !busy && !$past(busy, 3) |-> sda_oe) else $error("own select not acknowledged");
    AST_ACK_RELEASE: assert property (@(posedge scl) disable iff (locked)
        first && nbit == 4'h8 && !shv[0] && sda_oe |=> !sda_oe)
        else $error("acknowledge held too long");
    AST_BUSY_DEAF: assert property (@(posedge scl) disable iff (locked)
        busy && $past(busy, 3) |-> !sda_oe) else $error("answer during programming");
    AST_PROTECT_NACK: assert property (@(posedge scl) disable iff (locked)
        nbyte == 2'h2 && nbit == 4'h8 && write_protect_input && $past(write_protect_input, 3)
        |-> !sda_oe) else $error("data acknowledged under write protect");
    COV_SEL_ACK: cover property (@(posedge scl) first && nbit == 4'h8 && sda_oe);
    COV_PROG: cover property (@(posedge clk) $fell(busy));
    COV_LOCK: cover property (@(posedge clk) $rose(locked));
endmodule : tws_slave_port_asserts

bind tws_slave_port tws_slave_port_asserts #(.PROG_CYCLES_P(PROG_CYCLES_P)) chk (
    .clk(clk), .rst(rst), .power_good(power_good), .busy(busy), .locked(locked),
    .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .bus_identity_pins(bus_identity_pins), .write_protect_input(write_protect_input)
);
